// *** dv/ecgd_mod_model.sv ***
`default_nettype none
module ecgd_mod_model
    import ecgd_pkg::*;
(
    // modulator control from the block
    input  wire logic [NUM_CH-1:0] modClk,
    input  wire logic [NUM_CH-1:0] modPowerDown,
    // bit stream back to the block
    output var  logic [NUM_CH-1:0] modBit
);
    timeunit 1ns;
    timeprecision 1ps;
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        logic [2:0] ph = 3'h0;
        // one bit per modulator period, launched on its clock
        always @(posedge modClk[g])
            ph <= ph + 3'h1;
        // powered-down modulator drives no stream: ph[0], which holds while its clock is stopped
        assign modBit[g] = modPowerDown[g] ? ph[0] : (ph < 3'h5);
    end
endmodule
`default_nettype wire

// *** dv/ecgd_top_tb.sv ***
`default_nettype none
module ecgd_top_tb
    import ecgd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                          ref_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]                    htrans = 2'h0;
    logic [2:0]                    hsize = 3'h2;
    logic [31:0]                   haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic                          hreadyout;
    logic [NUM_CH-1:0]             modBitPin, modClk, modPowerDown, ampPowerDown, ampHires;
    logic [NUM_CH-1:0]             modZeroInput, ditherOn, paceValid, ecgValid, modIntReset;
    logic [NUM_CH-1:0]             paceSettled, ecgSettled;
    logic [NUM_CH-1:0][PACE_W-1:0] paceData;
    logic                          hresp;
    logic [NUM_CH-1:0]             largeInPin = 3'h0;
    logic [NUM_CH-1:0][FLAG_W-1:0] rangePins = '0;
    int                            bad_count = 0, n_checks = 0, cyc = 0, pulseCnt = 0;
    ecgd_top u_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .modBitPin(modBitPin),
        .modClk(modClk), .modPowerDown(modPowerDown), .ampPowerDown(ampPowerDown),
        .ampHires(ampHires), .modZeroInput(modZeroInput), .modIntReset(modIntReset),
        .ditherOn(ditherOn), .rangePins(rangePins), .largeInPin(largeInPin),
        .paceData(paceData), .paceValid(paceValid), .ecgData(), .ecgValid(ecgValid),
        .paceSettled(paceSettled), .ecgSettled(ecgSettled));
    ecgd_mod_model u_mod (.modClk(modClk), .modPowerDown(modPowerDown), .modBit(modBitPin));
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // cut a hang short
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            bad_count++;
            close_out();
        end
    end
    // integrator-reset pulses on channel two, one edge each
    always @(posedge ref_clk)
    begin
        if (modIntReset[1] === 1'b1)
            pulseCnt++;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, s);
            bad_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, hrdata);
    endtask
    task automatic pins(input int c, input logic [FLAG_W-1:0] v);
        rangePins[c] <= v;
        repeat (5) @(posedge ref_clk);
    endtask
    function automatic logic sig(input int sel, input int c);
        return sel == 0 ? paceValid[c] : sel == 1 ? ecgValid[c] : modClk[c];
    endfunction
    // cycles between two successive rises, sel: 0 pace, 1 ecg, 2 modulator clock
    task automatic gap(input int sel, input int c, input int lo, input int hi);
        int n;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            while (sig(sel, c) === 1'b1)
            begin
                @(posedge ref_clk);
                n++;
            end
            while (sig(sel, c) !== 1'b1)
            begin
                @(posedge ref_clk);
                n++;
            end
        end
        chk("sample spacing", 32'h1, 32'(n >= lo && n <= hi));
    endtask
    initial
    begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd("dither reg", OFS_DITHER, 32'h7);
        chk("ditherOn", 32'h7, 32'(ditherOn));
        rd("unmapped", 8'h30, 32'h0);
        chk("hresp", 32'h0, 32'(hresp));
        bus(1'b1, OFS_RES, 32'h0f);
        @(posedge ref_clk);
        chk("ampHires", 32'h7, 32'(ampHires));
        bus(1'b1, OFS_R1, 32'h1);
        bus(1'b1, OFS_R2, 32'h0);
        bus(1'b1, OFS_R3[0], 32'h0);
        gap(2, 0, 610, 611);
        gap(2, 1, 1220, 1221);
        gap(0, 0, 4880, 4888);
        gap(1, 0, 19520, 19552);
        // two ecg and eight pace samples since the last restart
        chk("ecgSettled", 32'h0, 32'(ecgSettled[0]));
        chk("paceSettled early", 32'h0, 32'(paceSettled[0]));
        gap(0, 0, 4880, 4888);
        @(posedge ref_clk);
        chk("paceSettled", 32'h1, 32'(paceSettled[0]));
        // stream mean +1/4, gain 2^20, top 16 of 27 bits
        chk("paceData", 32'h80, 32'(paceData[0]));
        bus(1'b1, OFS_R2, 32'h3);
        gap(0, 0, 9760, 9776);
        bus(1'b1, OFS_R2, 32'h1);
        gap(0, 0, 6100, 6108);
        // sticky flags and live sign: pin pattern pos-top, overrange and sign
        pins(0, 7'h31);
        chk("zero feed", 32'h1, 32'(modZeroInput[0]));
        rd("err ch1", OFS_ERR[0], 32'h31);
        pins(0, 7'h00);
        bus(1'b1, OFS_ERR[0], 32'h7f);
        rd("err ch1 cleared", OFS_ERR[0], 32'h0);
        bus(1'b1, OFS_FAULT, 32'h1);
        pins(0, 7'h11);
        rd("rail monitor off", OFS_ERR[0], 32'h10);
        pins(1, 7'h40);
        rd("err ch2", OFS_ERR[1], 32'h40);
        chk("modIntReset pulses", 32'h1, pulseCnt);
        bus(1'b1, OFS_SHDN, 32'h9);
        pins(0, 7'h31);
        chk("power down", 32'h3, {30'h0, modPowerDown[0], ampPowerDown[0]});
        bus(1'b1, OFS_ERR[0], 32'h7f);
        rd("amp down flags", OFS_ERR[0], 32'h0);
        largeInPin[2] <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk("dither off", 32'h3, 32'(ditherOn));
        close_out();
    end
endmodule
`default_nettype wire

// *** hw/ecgd_pkg.sv ***
`default_nettype none
package ecgd_pkg;
    localparam int NUM_CH     = 3;
    localparam int SINC_ORDER = 5;
    localparam int PACE_W     = 16;
    localparam int ECG_W      = 24;
    localparam int S1_IW      = 2;
    localparam int S1_GW      = 10;
    localparam int S2_GW      = 15;
    localparam int S3_GW      = 35;
    localparam int FLAG_W     = 7;
    // register byte offsets
    localparam logic [7:0] OFS_RES    = 8'h00;
    localparam logic [7:0] OFS_SHDN   = 8'h04;
    localparam logic [7:0] OFS_FAULT  = 8'h08;
    localparam logic [7:0] OFS_R1     = 8'h0c;
    localparam logic [7:0] OFS_R2     = 8'h10;
    localparam logic [7:0] OFS_R3 [NUM_CH]  = '{8'h14, 8'h18, 8'h1c};
    localparam logic [7:0] OFS_ERR [NUM_CH] = '{8'h20, 8'h24, 8'h28};
    localparam logic [7:0] OFS_DITHER = 8'h2c;
    // field positions
    localparam int RES_HIRES_LSB = 0;
    localparam int RES_FAST_LSB  = 3;
    localparam int SHDN_AMP_LSB  = 0;
    localparam int SHDN_MOD_LSB  = 3;
    localparam int FLG_POS_HI    = 0;
    localparam int FLG_POS_LO    = 1;
    localparam int FLG_NEG_HI    = 2;
    localparam int FLG_NEG_LO    = 3;
    localparam int FLG_DIF       = 4;
    localparam int FLG_SIGN      = 5;
    localparam int FLG_MOD_OR    = 6;
    // reset values
    localparam logic [5:0] RES_RST    = 6'h00;
    localparam logic [5:0] SHDN_RST   = 6'h00;
    localparam logic [2:0] FAULT_RST  = 3'h0;
    localparam logic [2:0] R1_RST     = 3'h0;
    localparam logic [1:0] R2_RST     = 2'h0;
    localparam logic [2:0] R3_RST     = 3'h0;
    localparam logic [2:0] DITHER_RST = 3'h7;
    // decimation ratios
    localparam logic [7:0] R1_STD = 8'h04;
    localparam logic [7:0] R1_DBL = 8'h02;
    localparam logic [7:0] R2_TABLE [4] = '{8'h04, 8'h05, 8'h06, 8'h08};
    localparam logic [7:0] R3_TABLE [8] =
        '{8'h04, 8'h06, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h40, 8'h80};
    // timing
    localparam longint CLK_HZ     = 125000000;
    localparam longint FS_LOW_HZ  = 102400;
    localparam longint FS_HIGH_HZ = 204800;
    localparam logic [31:0] INC_LOW  = 32'((FS_LOW_HZ << 32) / CLK_HZ);
    localparam logic [31:0] INC_HIGH = 32'((FS_HIGH_HZ << 32) / CLK_HZ);
    localparam logic [3:0] SETTLE_ECG      = 4'h5;
    localparam logic [3:0] SETTLE_PACE_STD = 4'h5;
    localparam logic [3:0] SETTLE_PACE_DBL = 4'ha;
endpackage
`default_nettype wire

// *** hw/ecgd_range_mon.sv ***
`default_nettype none
module ecgd_range_mon
    import ecgd_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // comparator pins
    input  wire logic [FLAG_W-1:0] flagPins,
    input  wire logic              largeInPin,
    // control
    input  wire logic              railOff,
    input  wire logic              ampOff,
    input  wire logic              ditherEn,
    input  wire logic [FLAG_W-1:0] clrBits,
    // results
    output var  logic [FLAG_W-1:0] status,
    output var  logic              modZero,
    output var  logic              intReset,
    output var  logic              ditherOn
);
    logic [FLAG_W:0]   meta_r;
    logic [FLAG_W:0]   sync_r;
    logic              modOrSeen_r;
    logic [FLAG_W-1:0] setMask;
    logic [FLAG_W-1:0] setBits;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= {largeInPin, flagPins};
            sync_r <= meta_r;
        end
    end

    always_comb
    begin
        setMask = '1;
        if (railOff)
            setMask[FLG_NEG_LO:FLG_POS_HI] = 4'h0;
        if (ampOff)
        begin
            setMask[FLG_DIF]  = 1'b0;
            setMask[FLG_SIGN] = 1'b0;
        end
        setBits = sync_r[FLAG_W-1:0] & setMask;
    end

    // a set arriving with its clear wins; sign is the live polarity
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            status      <= '0;
            modZero     <= 1'b0;
            intReset    <= 1'b0;
            modOrSeen_r <= 1'b0;
            ditherOn    <= 1'b0;
        end
        else
        begin
            status           <= (status & ~clrBits) | setBits;
            status[FLG_SIGN] <= setBits[FLG_SIGN];
            modZero          <= sync_r[FLG_DIF] & ~ampOff;
            modOrSeen_r      <= sync_r[FLG_MOD_OR];
            intReset         <= sync_r[FLG_MOD_OR] & ~modOrSeen_r;
            ditherOn         <= ditherEn & ~sync_r[FLAG_W];
        end
    end

    a_rail_gate: assert property (
        @(posedge ref_clk) disable iff (reset)
        railOff |=> (status[FLG_NEG_LO:FLG_POS_HI]
                     & ~$past(status[FLG_NEG_LO:FLG_POS_HI])) == 4'h0)
        else $error("rail flag set while monitor off");

    a_amp_gate: assert property (
        @(posedge ref_clk) disable iff (reset)
        ampOff |=> !modZero && !status[FLG_SIGN])
        else $error("overrange active with amplifier off");

    a_overrange_zero: assert property (
        @(posedge ref_clk) disable iff (reset)
        sync_r[FLG_DIF] && !ampOff |=> modZero && status[FLG_DIF])
        else $error("overrange not flagged or zero not fed");

    a_integ_reset: assert property (
        @(posedge ref_clk) disable iff (reset)
        intReset |-> status[FLG_MOD_OR] ##1 !intReset)
        else $error("integrator reset without flag or too long");

    a_dither_off: assert property (
        @(posedge ref_clk) disable iff (reset)
        sync_r[FLAG_W] |=> !ditherOn)
        else $error("dither stays on with large input");

    a_flag_sticky: assert property (
        @(posedge ref_clk) disable iff (reset)
        status[FLG_POS_HI] && !clrBits[FLG_POS_HI] |=> status[FLG_POS_HI])
        else $error("rail flag lost without clear");
endmodule
`default_nettype wire

// *** hw/ecgd_sinc5.sv ***
`default_nettype none
module ecgd_sinc5
    import ecgd_pkg::*;
#(
    parameter int IW = 2,
    parameter int GW = 10,
    parameter int OW = 12
)(
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          reset,
    // control
    input  wire logic [7:0]    ratio,
    input  wire logic          dblDelay,
    input  wire logic          clear,
    // input samples
    input  wire logic [IW-1:0] inData,
    input  wire logic          inValid,
    // decimated samples
    output var  logic [OW-1:0] outData,
    output var  logic          outValid
);
    localparam int AW = IW + GW;

    logic [AW-1:0] integ_r   [SINC_ORDER];
    logic [AW-1:0] combDly_r [SINC_ORDER];
    logic [AW-1:0] combDl2_r [SINC_ORDER];
    logic [AW-1:0] combTap   [SINC_ORDER+1];
    logic [7:0]    decCnt_r;
    logic          decimate;

    assign decimate = inValid && (decCnt_r == ratio - 8'h01);

    // two-sample comb delay keeps the kernel length when the ratio halves
    always_comb
    begin
        combTap[0] = integ_r[SINC_ORDER-1];
        for (int k = 0; k < SINC_ORDER; k++)
            combTap[k+1] = combTap[k] - (dblDelay ? combDl2_r[k] : combDly_r[k]);
    end

    // wraparound in the integrators is harmless, the combs undo it
    always_ff @(posedge ref_clk)
    begin
        if (reset || clear)
        begin
            for (int k = 0; k < SINC_ORDER; k++)
                integ_r[k] <= '0;
        end
        else if (inValid)
        begin
            integ_r[0] <= integ_r[0] + {{GW{inData[IW-1]}}, inData};
            for (int k = 1; k < SINC_ORDER; k++)
                integ_r[k] <= integ_r[k] + integ_r[k-1];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset || clear)
        begin
            decCnt_r <= 8'h00;
            outData  <= '0;
            outValid <= 1'b0;
            for (int k = 0; k < SINC_ORDER; k++)
            begin
                combDly_r[k] <= '0;
                combDl2_r[k] <= '0;
            end
        end
        else
        begin
            outValid <= decimate;
            if (inValid)
                decCnt_r <= decimate ? 8'h00 : decCnt_r + 8'h01;
            if (decimate)
            begin
                outData <= combTap[SINC_ORDER][AW-1 -: OW];
                for (int k = 0; k < SINC_ORDER; k++)
                begin
                    combDly_r[k] <= combTap[k];
                    combDl2_r[k] <= combDly_r[k];
                end
            end
        end
    end

    a_ratio_count: assert property (
        @(posedge ref_clk) disable iff (reset || clear)
        $stable(ratio) && !$past(clear) |-> decCnt_r < ratio)
        else $error("decimation counter beyond ratio");

    a_valid_strobe: assert property (
        @(posedge ref_clk) disable iff (reset || clear)
        outValid |-> $past(inValid) ##1 !outValid)
        else $error("output strobe not a single cycle");
endmodule
`default_nettype wire

// *** hw/ecgd_top.sv ***
`default_nettype none
module ecgd_top
    import ecgd_pkg::*;
(
    // clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           reset,
    // ahb-lite slave
    input  wire logic                           hsel,
    input  wire logic [31:0]                    haddr,
    input  wire logic [1:0]                     htrans,
    input  wire logic                           hwrite,
    input  wire logic [2:0]                     hsize,
    input  wire logic [31:0]                    hwdata,
    input  wire logic                           hready,
    output var  logic                           hreadyout,
    output var  logic                           hresp,
    output var  logic [31:0]                    hrdata,
    // modulator and amplifier side
    input  wire logic [NUM_CH-1:0]              modBitPin,
    output var  logic [NUM_CH-1:0]              modClk,
    output var  logic [NUM_CH-1:0]              modPowerDown,
    output var  logic [NUM_CH-1:0]              ampPowerDown,
    output var  logic [NUM_CH-1:0]              ampHires,
    output var  logic [NUM_CH-1:0]              modZeroInput,
    output var  logic [NUM_CH-1:0]              modIntReset,
    output var  logic [NUM_CH-1:0]              ditherOn,
    // comparator pins
    input  wire logic [NUM_CH-1:0][FLAG_W-1:0]  rangePins,
    input  wire logic [NUM_CH-1:0]              largeInPin,
    // sample streams
    output var  logic [NUM_CH-1:0][PACE_W-1:0]  paceData,
    output var  logic [NUM_CH-1:0]              paceValid,
    output var  logic [NUM_CH-1:0][ECG_W-1:0]   ecgData,
    output var  logic [NUM_CH-1:0]              ecgValid,
    output var  logic [NUM_CH-1:0]              paceSettled,
    output var  logic [NUM_CH-1:0]              ecgSettled
);
    logic [5:0]        res_r;
    logic [5:0]        shdn_r;
    logic [2:0]        fault_r;
    logic [2:0]        r1_r;
    logic [1:0]        r2_r;
    logic [2:0]        r3_r      [NUM_CH];
    logic [2:0]        dither_r;
    logic [FLAG_W-1:0] errStat   [NUM_CH];
    logic [FLAG_W-1:0] errClr    [NUM_CH];
    logic              addrPhase;
    logic              dpWrite_r;
    logic [7:0]        dpAddr_r;
    logic [31:0]       rdWord;
    logic              cfgWrite;
    logic              filtClear_r;

    // ---------------- bus slave ----------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addrPhase = hsel && htrans[1] && hready;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            dpWrite_r <= 1'b0;
            dpAddr_r  <= 8'h00;
            hrdata    <= 32'h0;
        end
        else
        begin
            // only whole-word writes land; narrower ones are dropped
            dpWrite_r <= addrPhase && hwrite && (hsize == 3'h2);
            dpAddr_r  <= haddr[7:0];
            if (addrPhase && !hwrite)
                hrdata <= rdWord;
        end
    end

    always_comb
    begin
        rdWord = 32'h0;
        case (haddr[7:0])
            OFS_RES:    rdWord[5:0] = res_r;
            OFS_SHDN:   rdWord[5:0] = shdn_r;
            OFS_FAULT:  rdWord[2:0] = fault_r;
            OFS_R1:     rdWord[2:0] = r1_r;
            OFS_R2:     rdWord[1:0] = r2_r;
            OFS_R3[0]:  rdWord[2:0] = r3_r[0];
            OFS_R3[1]:  rdWord[2:0] = r3_r[1];
            OFS_R3[2]:  rdWord[2:0] = r3_r[2];
            OFS_ERR[0]: rdWord[FLAG_W-1:0] = errStat[0];
            OFS_ERR[1]: rdWord[FLAG_W-1:0] = errStat[1];
            OFS_ERR[2]: rdWord[FLAG_W-1:0] = errStat[2];
            OFS_DITHER: rdWord[2:0] = dither_r;
            default:    rdWord = 32'h0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            res_r    <= RES_RST;
            shdn_r   <= SHDN_RST;
            fault_r  <= FAULT_RST;
            r1_r     <= R1_RST;
            r2_r     <= R2_RST;
            dither_r <= DITHER_RST;
            for (int c = 0; c < NUM_CH; c++)
                r3_r[c] <= R3_RST;
        end
        else if (dpWrite_r)
        begin
            if (dpAddr_r == OFS_RES)
                res_r <= hwdata[5:0];
            if (dpAddr_r == OFS_SHDN)
                shdn_r <= hwdata[5:0];
            if (dpAddr_r == OFS_FAULT)
                fault_r <= hwdata[2:0];
            if (dpAddr_r == OFS_R1)
                r1_r <= hwdata[2:0];
            if (dpAddr_r == OFS_R2)
                r2_r <= hwdata[1:0];
            if (dpAddr_r == OFS_DITHER)
                dither_r <= hwdata[2:0];
            for (int c = 0; c < NUM_CH; c++)
                if (dpAddr_r == OFS_R3[c])
                    r3_r[c] <= hwdata[2:0];
        end
    end

    // any rate or clock change restarts every filter from empty
    assign cfgWrite = dpWrite_r && (dpAddr_r == OFS_RES || dpAddr_r == OFS_R1
                      || dpAddr_r == OFS_R2 || dpAddr_r == OFS_R3[0]
                      || dpAddr_r == OFS_R3[1] || dpAddr_r == OFS_R3[2]);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            filtClear_r <= 1'b0;
        else
            filtClear_r <= cfgWrite;
    end

    assign ampPowerDown = shdn_r[SHDN_AMP_LSB +: NUM_CH];
    assign modPowerDown = shdn_r[SHDN_MOD_LSB +: NUM_CH];
    assign ampHires     = res_r[RES_HIRES_LSB +: NUM_CH];

    // ---------------- per-channel path ----------------
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        logic                    fast;
        logic                    modPd;
        logic                    chClear;
        logic [31:0]             phase_r;
        logic [32:0]             phaseSum;
        logic                    tick_r;
        logic                    bitMeta_r;
        logic                    bitSync_r;
        logic [1:0]              s1In;
        logic [S1_IW+S1_GW-1:0]  s1Data;
        logic                    s1Valid;
        logic [7:0]              ratio1;
        logic [3:0]              ecgCnt_r;
        logic [3:0]              paceCnt_r;
        logic [3:0]              paceNeed;
        logic                    fastD_r;
        logic                    gapOk_r;
        logic [11:0]             gapCnt_r;

        assign fast     = res_r[RES_FAST_LSB + c];
        assign modPd    = modPowerDown[c];
        assign chClear  = filtClear_r || modPd;
        assign phaseSum = {1'b0, phase_r} + {1'b0, fast ? INC_HIGH : INC_LOW};
        assign modClk[c] = phase_r[31];

        // phase accumulator: carry out marks one modulator period
        always_ff @(posedge ref_clk)
        begin
            if (reset || modPd)
            begin
                phase_r <= 32'h0;
                tick_r  <= 1'b0;
            end
            else
            begin
                phase_r <= phaseSum[31:0];
                tick_r  <= phaseSum[32];
            end
        end

        always_ff @(posedge ref_clk)
        begin
            if (reset)
            begin
                bitMeta_r <= 1'b0;
                bitSync_r <= 1'b0;
            end
            else
            begin
                bitMeta_r <= modBitPin[c];
                bitSync_r <= bitMeta_r;
            end
        end

        assign s1In   = bitSync_r ? 2'h1 : 2'h3;
        assign ratio1 = r1_r[c] ? R1_DBL : R1_STD;

        ecgd_sinc5 #(.IW(S1_IW), .GW(S1_GW), .OW(S1_IW + S1_GW)) u_stage1 (
            .ref_clk  (ref_clk),
            .reset    (reset),
            .ratio    (ratio1),
            .dblDelay (r1_r[c]),
            .clear    (chClear),
            .inData   (s1In),
            .inValid  (tick_r),
            .outData  (s1Data),
            .outValid (s1Valid)
        );

        ecgd_sinc5 #(.IW(S1_IW + S1_GW), .GW(S2_GW), .OW(PACE_W)) u_stage2 (
            .ref_clk  (ref_clk),
            .reset    (reset),
            .ratio    (R2_TABLE[r2_r]),
            .dblDelay (1'b0),
            .clear    (chClear),
            .inData   (s1Data),
            .inValid  (s1Valid),
            .outData  (paceData[c]),
            .outValid (paceValid[c])
        );

        ecgd_sinc5 #(.IW(PACE_W), .GW(S3_GW), .OW(ECG_W)) u_stage3 (
            .ref_clk  (ref_clk),
            .reset    (reset),
            .ratio    (R3_TABLE[r3_r[c]]),
            .dblDelay (1'b0),
            .clear    (chClear),
            .inData   (paceData[c]),
            .inValid  (paceValid[c]),
            .outData  (ecgData[c]),
            .outValid (ecgValid[c])
        );

        ecgd_range_mon u_range (
            .ref_clk    (ref_clk),
            .reset      (reset),
            .flagPins   (rangePins[c]),
            .largeInPin (largeInPin[c]),
            .railOff    (fault_r[c]),
            .ampOff     (ampPowerDown[c]),
            .ditherEn   (dither_r[c]),
            .clrBits    (errClr[c]),
            .status     (errStat[c]),
            .modZero    (modZeroInput[c]),
            .intReset   (modIntReset[c]),
            .ditherOn   (ditherOn[c])
        );

        assign errClr[c] = (dpWrite_r && dpAddr_r == OFS_ERR[c])
                           ? hwdata[FLAG_W-1:0] : '0;

        // settling counts whole output samples since the last restart
        assign paceNeed = r1_r[c] ? SETTLE_PACE_DBL : SETTLE_PACE_STD;

        always_ff @(posedge ref_clk)
        begin
            if (reset || chClear)
            begin
                ecgCnt_r  <= 4'h0;
                paceCnt_r <= 4'h0;
            end
            else
            begin
                if (ecgValid[c] && ecgCnt_r != SETTLE_ECG)
                    ecgCnt_r <= ecgCnt_r + 4'h1;
                if (paceValid[c] && paceCnt_r != paceNeed)
                    paceCnt_r <= paceCnt_r + 4'h1;
            end
        end

        assign ecgSettled[c]  = (ecgCnt_r == SETTLE_ECG);
        assign paceSettled[c] = (paceCnt_r == paceNeed);

        // helper for the modulator period check
        always_ff @(posedge ref_clk)
        begin
            if (reset || modPd)
            begin
                fastD_r  <= 1'b0;
                gapOk_r  <= 1'b0;
                gapCnt_r <= 12'h000;
            end
            else
            begin
                fastD_r  <= fast;
                gapCnt_r <= tick_r ? 12'h000 : gapCnt_r + 12'h001;
                if (fast != fastD_r)
                    gapOk_r <= 1'b0;
                else if (tick_r)
                    gapOk_r <= 1'b1;
            end
        end

        a_mod_period: assert property (
            @(posedge ref_clk) disable iff (reset || modPd)
            tick_r && gapOk_r && fast == fastD_r |->
                (fast ? (gapCnt_r inside {[12'd609:12'd610]})
                      : (gapCnt_r inside {[12'd1219:12'd1220]})))
            else $error("modulator period off");

        a_ecg_follows: assert property (
            @(posedge ref_clk) disable iff (reset || chClear)
            ecgValid[c] |-> $past(paceValid[c]))
            else $error("ecg sample without pace sample");

        a_ecg_settle: assert property (
            @(posedge ref_clk) disable iff (reset || chClear)
            ecgValid[c] && ecgCnt_r == SETTLE_ECG - 4'h1 |=> ecgSettled[c])
            else $error("ecg settled flag late");
    end
endmodule
`default_nettype wire
